// [inc/utb_pkg.sv]
package utb_pkg;
	// ==========================================================
	// memory geometry
	localparam logic [15:0] RAM_LIMIT     = 16'h1000;
	localparam logic [15:0] ISO_HALF_MAX  = 16'h0800;
	localparam int          RAM_WORDS     = 2048;
	localparam logic [15:0] TD_HDR_BYTES  = 16'h0008;
	// ==========================================================
	// command indices (bit 7 of a command byte selects write)
	localparam int          CMD_WR_BIT      = 7;
	localparam logic [6:0]  REG_DMA_CFG     = 7'h21;
	localparam logic [6:0]  REG_XFER_COUNT  = 7'h22;
	localparam logic [6:0]  REG_IRQ_STATUS  = 7'h24;
	localparam logic [6:0]  REG_IRQ_MASK    = 7'h25;
	localparam logic [6:0]  REG_ISO_LEN     = 7'h2A;
	localparam logic [6:0]  REG_ACK_LEN     = 7'h2B;
	localparam logic [6:0]  REG_FILL_STATUS = 7'h2C;
	localparam logic [6:0]  PORT_ISO        = 7'h40;
	localparam logic [6:0]  PORT_ACK        = 7'h41;
	// ==========================================================
	// field positions
	localparam int ST_PING_FULL = 0;
	localparam int ST_PONG_FULL = 1;
	localparam int ST_ACK_FULL  = 2;
	localparam int ST_PING_DONE = 3;
	localparam int ST_PONG_DONE = 4;
	localparam int ST_ACK_DONE  = 5;
	localparam int IRQ_ISO      = 0;
	localparam int IRQ_ACK      = 1;
	localparam int IRQ_EOT      = 2;
	localparam int DMA_EN       = 2;
	localparam int DMA_DIR_RD   = 3;
	// ==========================================================
	// reset values
	localparam logic [15:0] RST_ISO_LEN = 16'h0000;
	localparam logic [15:0] RST_ACK_LEN = 16'h1000;
	localparam logic [15:0] RST_COUNT   = 16'h0000;
	localparam logic [3:0]  RST_DMA_CFG = 4'h0;
	// ==========================================================
	// types
	typedef enum logic [1:0] {
		UTB_DIR_SETUP = 2'b00,
		UTB_DIR_OUT   = 2'b01,
		UTB_DIR_IN    = 2'b10,
		UTB_DIR_RSVD  = 2'b11
	} utb_dir_t;
	typedef enum logic [1:0] {
		UTB_BURST_SINGLE = 2'b00,
		UTB_BURST_1      = 2'b01,
		UTB_BURST_4      = 2'b10,
		UTB_BURST_8      = 2'b11
	} utb_burst_t;
	typedef enum logic {
		UTB_DMA_IDLE = 1'b0,
		UTB_DMA_RUN  = 1'b1
	} utb_dma_st_t;
	// descriptor header, word 3 in the top bits, word 0 in the low bits
	typedef struct packed {
		logic [7:0]  rsvd3;
		logic        format;
		logic [6:0]  target_function_addr;
		logic        single_transaction_limit;
		logic [2:0]  rsvd2;
		utb_dir_t    token_direction;
		logic [9:0]  total_bytes;
		logic [3:0]  endpoint;
		logic        last;
		logic        speed;
		logic [9:0]  max_packet;
		logic [3:0]  cc;
		logic        active;
		logic        toggle;
		logic [9:0]  actual_bytes;
	} utb_td_hdr_t;
	typedef struct packed {
		logic        cmd_wr;
		logic        data_wr;
		logic        data_rd;
		logic [15:0] wdata;
	} utb_host_req_t;
	typedef struct packed {
		logic        req;
		logic        we;
		logic        iso;
		logic [11:0] addr;
		logic [7:0]  wdata;
		logic        done;
		logic        sof;
	} utb_eng_req_t;
endpackage

// [rtl/utb_buffer_ram.sv]
// Overview of operation
// - 4-kbyte buffer shared by processor and engine
// - buffer split into ack and iso regions
// - iso region is ping-pong double buffer
// - ack region is single buffer, non iso
// - both iso halves equal programmed iso length
// - engine uses other iso half concurrently
// - region lengths writable any time
// - iso half capped at 2 kbytes
// - status register reports regions full
// - done status means results ready
// - each interrupt source has its own mask
// - buffer data by programmed io or dma
// - dma single cycle or bursts 1/4/8
// - out/setup payload follows its descriptor
// - in descriptor reserves total bytes space
// - same descriptor both regions, device swaps halves
// - descriptors and payloads 4-byte aligned
// - format flag one for isochronous endpoints
// - 7-bit target function address per descriptor
// - single transaction bit limits interrupt descriptor
// - pointer reaching count raises end flag
// - port access moves two bytes, low even
// - sof swaps halves; both full sets cpu to second half
// - last flag ends region's descriptor list
module utb_buffer_ram
	import utb_pkg::*;
(
	input  wire logic          ref_clk_i,
	input  wire logic          reset_n_i,
	input  wire utb_host_req_t host_i,
	output logic [15:0]        host_rdata_o,
	output logic               host_irq_o,
	output logic               dma_req_o,
	input  wire logic          dma_ack_i,
	input  wire utb_eng_req_t  eng_i,
	output logic [7:0]         eng_rdata_o,
	input  wire logic          eng_hdr_valid_i,
	input  wire logic [11:0]   eng_hdr_off_i,
	input  wire utb_td_hdr_t   eng_hdr_i,
	output logic [11:0]        eng_next_off_o,
	output logic               eng_list_end_o,
	output logic               eng_one_txn_o,
	output logic [6:0]         eng_func_addr_o,
	output logic [5:0]         fill_status_o
);
	// ==========================================================
	// state
	typedef struct packed {
		logic [15:0] iso_len;
		logic [15:0] ack_len;
		logic [15:0] xfer_count;
		logic [2:0]  irq_st;
		logic [2:0]  irq_mask;
		logic [3:0]  dma_cfg;
		logic [5:0]  fill;
		logic [6:0]  cmd;
		logic        cmd_write;
		logic [11:0] ptr;
		logic [15:0] byte_cnt;
		logic        cpu_half;
		utb_dma_st_t dma_st;
		logic [3:0]  dma_beats;
		logic        irq;
		logic        dma_req;
		logic [11:0] next_off;
		logic        list_end;
		logic        one_txn;
		logic [6:0]  func_addr;
	} utb_state_t;

	utb_state_t    state_reg;
	utb_state_t    state_next;
	logic [15:0]   mem [RAM_WORDS];
	logic [15:0]   iso_half;
	logic          is_port;
	logic          port_acc;
	logic          port_wr;
	logic          eot_hit;
	logic          len_wr;
	logic [11:0]   cpu_addr;
	logic [11:0]   cpu_addr_next;
	logic [11:0]   eng_addr;
	logic [15:0]   host_rdata_reg;
	logic [7:0]    eng_rdata_reg;

	// ==========================================================
	// helpers
	// absolute byte address of an offset inside a region
	function automatic logic [11:0] abs_addr(input logic iso,
			input logic half, input logic [15:0] ack_len,
			input logic [15:0] half_len, input logic [11:0] off);
		logic [15:0] base;
		base = iso ? ack_len + (half ? half_len : 16'h0000) : 16'h0000;
		abs_addr = 12'(base + {4'h0, off});
	endfunction

	// bursts of one and single cycle both drop after every beat
	function automatic logic [3:0] burst_len(input logic [1:0] sel);
		case (utb_burst_t'(sel))
			UTB_BURST_4: burst_len = 4'h4;
			UTB_BURST_8: burst_len = 4'h8;
			default:     burst_len = 4'h1;
		endcase
	endfunction

	function automatic logic [15:0] reg_read(input utb_state_t s);
		case (s.cmd)
			REG_DMA_CFG:     reg_read = {12'h000, s.dma_cfg};
			REG_XFER_COUNT:  reg_read = s.xfer_count;
			REG_IRQ_STATUS:  reg_read = {13'h0000, s.irq_st};
			REG_IRQ_MASK:    reg_read = {13'h0000, s.irq_mask};
			REG_ISO_LEN:     reg_read = s.iso_len;
			REG_ACK_LEN:     reg_read = s.ack_len;
			REG_FILL_STATUS: reg_read = {10'h000, s.fill};
			default:         reg_read = 16'h0000;
		endcase
	endfunction

	// ==========================================================
	// decode of the current access
	// halves never exceed the per-half cap, whatever software wrote
	assign iso_half = (state_reg.iso_len > ISO_HALF_MAX) ?
			ISO_HALF_MAX : state_reg.iso_len;
	assign is_port  = (state_reg.cmd == PORT_ISO) ||
			(state_reg.cmd == PORT_ACK);
	assign port_acc = is_port && (host_i.data_wr || host_i.data_rd ||
			dma_ack_i);
	assign port_wr  = dma_ack_i ? !state_reg.dma_cfg[DMA_DIR_RD] :
			host_i.data_wr;
	assign eot_hit  = port_acc &&
			(16'(state_reg.byte_cnt + 16'h0002) >=
			state_reg.xfer_count);
	assign len_wr   = host_i.data_wr && state_reg.cmd_write &&
			((state_reg.cmd == REG_ISO_LEN) ||
			(state_reg.cmd == REG_ACK_LEN));
	// processor side gets one half, the engine the other
	assign cpu_addr = abs_addr(state_reg.cmd == PORT_ISO,
			state_reg.cpu_half, state_reg.ack_len, iso_half,
			state_reg.ptr);
	assign cpu_addr_next = abs_addr(state_next.cmd == PORT_ISO,
			state_next.cpu_half, state_next.ack_len, iso_half,
			state_next.ptr);
	assign eng_addr = abs_addr(eng_i.iso, !state_reg.cpu_half,
			state_reg.ack_len, iso_half, eng_i.addr);

	// ==========================================================
	// next state
	always_comb begin
		state_next = state_reg;
		if (host_i.cmd_wr) begin
			state_next.cmd       = host_i.wdata[6:0];
			state_next.cmd_write = host_i.wdata[CMD_WR_BIT];
			state_next.ptr       = 12'h000;
			state_next.byte_cnt  = 16'h0000;
		end
		// register writes; status clears before any set below
		if (host_i.data_wr && state_reg.cmd_write && !is_port) begin
			case (state_reg.cmd)
				REG_DMA_CFG:    state_next.dma_cfg = host_i.wdata[3:0];
				REG_XFER_COUNT: state_next.xfer_count = host_i.wdata;
				REG_IRQ_STATUS: state_next.irq_st =
						state_reg.irq_st & ~host_i.wdata[2:0];
				REG_IRQ_MASK:   state_next.irq_mask = host_i.wdata[2:0];
				REG_ISO_LEN:    state_next.iso_len = host_i.wdata;
				REG_ACK_LEN:    state_next.ack_len = host_i.wdata;
				default:        state_next.cmd_write = state_reg.cmd_write;
			endcase
		end
		if (len_wr) begin
			state_next.ptr      = 12'h000;
			state_next.byte_cnt = 16'h0000;
		end
		// each port beat moves one 16-bit word
		if (port_acc) begin
			state_next.ptr      = 12'(state_reg.ptr + 12'h002);
			state_next.byte_cnt = 16'(state_reg.byte_cnt + 16'h0002);
		end
		if (eot_hit && !port_wr) begin
			// results read back: region is empty again
			if (state_reg.cmd == PORT_ACK) begin
				state_next.fill[ST_ACK_FULL] = 1'b0;
				state_next.fill[ST_ACK_DONE] = 1'b0;
			end else if (state_reg.cpu_half) begin
				state_next.fill[ST_PONG_FULL] = 1'b0;
				state_next.fill[ST_PONG_DONE] = 1'b0;
			end else begin
				state_next.fill[ST_PING_FULL] = 1'b0;
				state_next.fill[ST_PING_DONE] = 1'b0;
			end
		end
		if (eot_hit) begin
			state_next.irq_st[IRQ_EOT] = 1'b1;
			if (port_wr) begin
				if (state_reg.cmd == PORT_ACK) begin
					state_next.fill[ST_ACK_FULL] = 1'b1;
				end else if (state_reg.cpu_half) begin
					state_next.fill[ST_PONG_FULL] = 1'b1;
				end else begin
					state_next.fill[ST_PING_FULL] = 1'b1;
				end
			end
		end
		// engine finished its list: data ready for the processor
		if (eng_i.done) begin
			if (!eng_i.iso) begin
				state_next.fill[ST_ACK_DONE] = 1'b1;
				state_next.irq_st[IRQ_ACK]   = 1'b1;
			end else if (state_reg.cpu_half) begin
				state_next.fill[ST_PING_DONE] = 1'b1;
			end else begin
				state_next.fill[ST_PONG_DONE] = 1'b1;
			end
		end
		// frame start flips the halves; with both loaded the processor goes to the second half
		if (eng_i.sof) begin
			state_next.irq_st[IRQ_ISO] = 1'b1;
			if (state_reg.fill[ST_PING_FULL] &&
					state_reg.fill[ST_PONG_FULL]) begin
				state_next.cpu_half = 1'b1;
			end else begin
				state_next.cpu_half = !state_reg.cpu_half;
			end
		end
		// dma: request while words remain, pause after each burst
		case (state_reg.dma_st)
			UTB_DMA_IDLE: begin
				state_next.dma_beats = 4'h0;
				if (state_reg.dma_cfg[DMA_EN] && is_port && !eot_hit &&
						(state_reg.byte_cnt < state_reg.xfer_count)) begin
					state_next.dma_st = UTB_DMA_RUN;
				end
			end
			UTB_DMA_RUN: begin
				if (dma_ack_i) begin
					state_next.dma_beats = 4'(state_reg.dma_beats + 4'h1);
					if (eot_hit || (4'(state_reg.dma_beats + 4'h1) ==
							burst_len(state_reg.dma_cfg[1:0]))) begin
						state_next.dma_st = UTB_DMA_IDLE;
					end
				end
				if (!state_reg.dma_cfg[DMA_EN] || host_i.cmd_wr) begin
					state_next.dma_st = UTB_DMA_IDLE;
				end
			end
			default: state_next.dma_st = UTB_DMA_IDLE;
		endcase
		state_next.dma_req = (state_next.dma_st == UTB_DMA_RUN);
		// descriptor walk: header, then payload or reserved space
		if (eng_hdr_valid_i) begin
			state_next.next_off = 12'((16'(eng_hdr_off_i) + TD_HDR_BYTES +
					16'(eng_hdr_i.total_bytes) + 16'h0003) &
					16'hFFFC);
			state_next.list_end  = eng_hdr_i.last;
			state_next.one_txn   = eng_hdr_i.single_transaction_limit &&
					!eng_hdr_i.format;
			state_next.func_addr = eng_hdr_i.target_function_addr;
		end
		state_next.irq = |(state_next.irq_st &
				state_next.irq_mask);
	end

	// ==========================================================
	// state register
	always_ff @(posedge ref_clk_i) begin
		if (!reset_n_i) begin
			state_reg            <= '0;
			state_reg.iso_len    <= RST_ISO_LEN;
			state_reg.ack_len    <= RST_ACK_LEN;
			state_reg.xfer_count <= RST_COUNT;
			state_reg.dma_cfg    <= RST_DMA_CFG;
			state_reg.dma_st     <= UTB_DMA_IDLE;
		end else begin
			state_reg <= state_next;
		end
	end

	// ==========================================================
	// buffer memory, word wide; low byte is the even address
	// read data is fetched from the next pointer so it is ready
	// for the very next strobe (one word per clock, 80 Mbyte/s)
	always_ff @(posedge ref_clk_i) begin
		if (port_acc && port_wr) begin
			mem[cpu_addr[11:1]] <= host_i.wdata;
		end
		if (eng_i.req && eng_i.we && eng_addr[0]) begin
			mem[eng_addr[11:1]][15:8] <= eng_i.wdata;
		end else if (eng_i.req && eng_i.we) begin
			mem[eng_addr[11:1]][7:0] <= eng_i.wdata;
		end
		eng_rdata_reg  <= eng_addr[0] ? mem[eng_addr[11:1]][15:8] :
				mem[eng_addr[11:1]][7:0];
		host_rdata_reg <= ((state_next.cmd == PORT_ISO) ||
				(state_next.cmd == PORT_ACK)) ?
				mem[cpu_addr_next[11:1]] : reg_read(state_next);
	end

	// ==========================================================
	// outputs
	assign host_rdata_o    = host_rdata_reg;
	assign eng_rdata_o     = eng_rdata_reg;
	assign host_irq_o      = state_reg.irq;
	assign dma_req_o       = state_reg.dma_req;
	assign eng_next_off_o  = state_reg.next_off;
	assign eng_list_end_o  = state_reg.list_end;
	assign eng_one_txn_o   = state_reg.one_txn;
	assign eng_func_addr_o = state_reg.func_addr;
	assign fill_status_o   = state_reg.fill;

	// ==========================================================
	// checks
	AST_EOT_FLAG: assert property (@(posedge ref_clk_i)
		disable iff (!reset_n_i) eot_hit |=> state_reg.irq_st[IRQ_EOT])
		else $error("end of transfer flag not raised");
	AST_PTR_STEP: assert property (@(posedge ref_clk_i)
		disable iff (!reset_n_i)
		port_acc && !host_i.cmd_wr && !len_wr |=>
		state_reg.ptr == 12'($past(state_reg.ptr) + 12'h002))
		else $error("pointer did not advance by two");
	AST_SWAP: assert property (@(posedge ref_clk_i)
		disable iff (!reset_n_i)
		eng_i.sof && !(state_reg.fill[ST_PING_FULL] &&
		state_reg.fill[ST_PONG_FULL]) |=>
		state_reg.cpu_half != $past(state_reg.cpu_half))
		else $error("halves not swapped at frame start");
	AST_NO_SWAP: assert property (@(posedge ref_clk_i)
		disable iff (!reset_n_i)
		eng_i.sof && state_reg.fill[ST_PING_FULL] &&
		state_reg.fill[ST_PONG_FULL] |=> state_reg.cpu_half)
		else $error("processor not left on second half");
	AST_HALF_CAP: assert property (@(posedge ref_clk_i)
		disable iff (!reset_n_i) iso_half <= ISO_HALF_MAX &&
		(state_reg.iso_len > ISO_HALF_MAX ||
		iso_half == state_reg.iso_len))
		else $error("iso half above cap or not programmed length");
	AST_LEN_PTR: assert property (@(posedge ref_clk_i)
		disable iff (!reset_n_i) len_wr && !port_acc |=>
		state_reg.ptr == 12'h000 && state_reg.byte_cnt == 16'h0000)
		else $error("length write kept old pointer");
	AST_ALIGN: assert property (@(posedge ref_clk_i)
		disable iff (!reset_n_i) eng_hdr_valid_i |=>
		eng_next_off_o[1:0] == 2'b00 &&
		eng_next_off_o >= 12'($past(eng_hdr_off_i) + 12'h008))
		else $error("next descriptor misplaced");
	AST_BURST: assert property (@(posedge ref_clk_i)
		disable iff (!reset_n_i)
		state_reg.dma_beats <= burst_len(state_reg.dma_cfg[1:0]))
		else $error("dma burst too long");
	AST_FULL_SET: assert property (@(posedge ref_clk_i)
		disable iff (!reset_n_i)
		eot_hit && port_wr && state_reg.cmd == PORT_ACK |=>
		fill_status_o[ST_ACK_FULL])
		else $error("ack region not marked full");
	AST_IRQ: assert property (@(posedge ref_clk_i)
		disable iff (!reset_n_i)
		host_irq_o == |(state_reg.irq_st & state_reg.irq_mask))
		else $error("interrupt output disagrees with mask");
endmodule

// [verification/utb_dma_partner.sv]
// ==========================================================
// processor-side dma responder: acks each request beat
module utb_dma_partner (
	input  wire logic ref_clk_i,
	input  wire logic reset_n_i,
	input  wire logic slow_i,
	input  wire logic dma_req_i,
	output logic      dma_ack_o,
	output int        ack_count_o
);
	timeunit 1ns;
	timeprecision 1ps;

	logic [1:0] wait_reg;

	// one ack per beat, never two in a row, so a request that
	// drops after its last beat is not acked again
	always @(posedge ref_clk_i) begin
		if (!reset_n_i) begin
			dma_ack_o   <= 1'b0;
			wait_reg    <= 2'd0;
			ack_count_o <= 0;
		end else begin
			dma_ack_o <= 1'b0;
			if (dma_req_i && !dma_ack_o) begin
				// slow mode stalls three cycles per beat
				if (!slow_i || wait_reg == 2'd3) begin
					dma_ack_o   <= 1'b1;
					ack_count_o <= ack_count_o + 1;
					wait_reg    <= 2'd0;
				end else begin
					wait_reg <= wait_reg + 2'd1;
				end
			end
		end
	end
endmodule

// [verification/utb_buffer_ram_tb.sv]
module utb_buffer_ram_tb import utb_pkg::*;;
	timeunit 1ns;
	timeprecision 1ps;

	typedef struct packed {
		logic [6:0]  idx;
		logic [15:0] val;
		logic [15:0] exp;
	} utb_row_t;

	logic          ref_clk = 1'b0;
	logic          reset_n = 1'b0;
	utb_host_req_t host    = '0;
	utb_eng_req_t  eng     = '0;
	utb_td_hdr_t   hdr     = '0;
	logic          hdr_valid = 1'b0;
	logic [11:0]   hdr_off = 12'h000;
	logic          slow    = 1'b0;
	logic [15:0]   host_rdata;
	logic          host_irq;
	logic          dma_req;
	logic          dma_ack;
	logic [7:0]    eng_rdata;
	logic [11:0]   next_off;
	logic          list_end;
	logic          one_txn;
	logic [6:0]    func_addr;
	logic [5:0]    fill_status;
	int            ack_count;
	int            bad_count    = 0;
	int            total_checks = 0;
	logic [15:0]   v;
	logic [7:0]    b;
	logic [15:0]   words [4] = '{16'h0201, 16'h0403, 16'h0605, 16'h0807};
	utb_row_t      rows  [5] = '{
		'{REG_ACK_LEN,     16'h0800, 16'h0800},
		'{REG_ISO_LEN,     16'h0400, 16'h0400},
		'{REG_XFER_COUNT,  16'h0050, 16'h0050},
		'{REG_FILL_STATUS, 16'hFFFF, 16'h0000},
		'{7'h30,           16'h1234, 16'h0000}};

	// ==========================================================
	// clock and instances
	always #12.5 ref_clk = ~ref_clk;

	utb_buffer_ram u_utb_buffer_ram (
		.ref_clk_i       (ref_clk),
		.reset_n_i       (reset_n),
		.host_i          (host),
		.host_rdata_o    (host_rdata),
		.host_irq_o      (host_irq),
		.dma_req_o       (dma_req),
		.dma_ack_i       (dma_ack),
		.eng_i           (eng),
		.eng_rdata_o     (eng_rdata),
		.eng_hdr_valid_i (hdr_valid),
		.eng_hdr_off_i   (hdr_off),
		.eng_hdr_i       (hdr),
		.eng_next_off_o  (next_off),
		.eng_list_end_o  (list_end),
		.eng_one_txn_o   (one_txn),
		.eng_func_addr_o (func_addr),
		.fill_status_o   (fill_status)
	);

	utb_dma_partner u_utb_dma_partner (
		.ref_clk_i   (ref_clk),
		.reset_n_i   (reset_n),
		.slow_i      (slow),
		.dma_req_i   (dma_req),
		.dma_ack_o   (dma_ack),
		.ack_count_o (ack_count)
	);

	// ==========================================================
	// shared tasks
	task automatic check(input logic [15:0] got, input logic [15:0] exp);
		total_checks++;
		if (got !== exp) begin
			bad_count++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// one bus pulse; wdata is left standing for dma beats
	task automatic host_op(input logic c, input logic w, input logic r,
			input logic [15:0] d);
		@(posedge ref_clk);
		host <= '{c, w, r, d};
		@(posedge ref_clk);
		host.cmd_wr  <= 1'b0;
		host.data_wr <= 1'b0;
		host.data_rd <= 1'b0;
		#1;
	endtask

	task automatic reg_wr(input logic [6:0] idx, input logic [15:0] val);
		host_op(1'b1, 1'b0, 1'b0, {8'h00, 1'b1, idx});
		host_op(1'b0, 1'b1, 1'b0, val);
	endtask

	task automatic reg_rd(input logic [6:0] idx, output logic [15:0] val);
		host_op(1'b1, 1'b0, 1'b0, {9'h000, idx});
		val = host_rdata;
	endtask

	task automatic eng_rd(input logic iso, input logic [11:0] a,
			output logic [7:0] d);
		@(posedge ref_clk);
		eng <= '{1'b1, 1'b0, iso, a, 8'h00, 1'b0, 1'b0};
		@(posedge ref_clk);
		eng <= '0;
		#1;
		d = eng_rdata;
	endtask

	task automatic give_verdict();
		$display("checks=%0d mismatches=%0d", total_checks, bad_count);
		if (bad_count == 0 && total_checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	// ==========================================================
	// watchdog: whole run needs well under 2000 cycles
	initial begin
		repeat (20000) @(posedge ref_clk);
		bad_count++;
		give_verdict();
	end

	// ==========================================================
	// main sequence
	initial begin
		repeat (5) @(posedge ref_clk);
		reset_n <= 1'b1;
		// reset values
		reg_rd(REG_ISO_LEN, v);
		check(v, RST_ISO_LEN);
		reg_rd(REG_ACK_LEN, v);
		check(v, RST_ACK_LEN);
		check({10'h000, fill_status}, 16'h0000);
		check({14'h0000, host_irq, dma_req}, 16'h0000);
		// register rows; sizes kept within the ram
		foreach (rows[i]) begin
			reg_wr(rows[i].idx, rows[i].val);
			reg_rd(rows[i].idx, v);
			check(v, rows[i].exp);
		end
		// iso: cpu fills ping, frame start hands it to the engine
		reg_wr(REG_ISO_LEN, 16'h0010);
		host_op(1'b1, 1'b0, 1'b0, {8'h00, 1'b1, PORT_ISO});
		host_op(1'b0, 1'b1, 1'b0, 16'hA55A);
		@(posedge ref_clk);
		eng.sof <= 1'b1;
		@(posedge ref_clk);
		eng.sof <= 1'b0;
		eng_rd(1'b1, 12'h000, b);
		check({8'h00, b}, 16'h005A);
		eng_rd(1'b1, 12'h001, b);
		check({8'h00, b}, 16'h00A5);
		// ack region by programmed io, written only while empty
		reg_wr(REG_ACK_LEN, 16'h0800);
		reg_wr(REG_XFER_COUNT, 16'h0008);
		host_op(1'b1, 1'b0, 1'b0, {8'h00, 1'b1, PORT_ACK});
		for (int i = 0; i < 4; i++) begin
			if (i == 3)
				check({15'h0000, fill_status[ST_ACK_FULL]}, 16'h0000);
			host_op(1'b0, 1'b1, 1'b0, words[i]);
		end
		@(posedge ref_clk);
		#1;
		check({15'h0000, fill_status[ST_ACK_FULL]}, 16'h0001);
		check({15'h0000, host_irq}, 16'h0000);
		reg_rd(REG_IRQ_STATUS, v);
		check({15'h0000, v[IRQ_EOT]}, 16'h0001);
		eng_rd(1'b0, 12'h000, b);
		check({8'h00, b}, 16'h0001);
		eng_rd(1'b0, 12'h003, b);
		check({8'h00, b}, 16'h0004);
		// engine stores a result byte and reports its list done
		@(posedge ref_clk);
		eng <= '{1'b1, 1'b1, 1'b0, 12'h008, 8'h77, 1'b1, 1'b0};
		@(posedge ref_clk);
		eng <= '0;
		@(posedge ref_clk);
		#1;
		check({10'h000, fill_status}, 16'h0024);
		eng_rd(1'b0, 12'h008, b);
		check({8'h00, b}, 16'h0077);
		// unmask, then clear the end flag
		reg_wr(REG_IRQ_MASK, 16'h0004);
		@(posedge ref_clk);
		#1;
		check({15'h0000, host_irq}, 16'h0001);
		reg_wr(REG_IRQ_STATUS, 16'h0004);
		@(posedge ref_clk);
		#1;
		check({15'h0000, host_irq}, 16'h0000);
		// read back from the base after a length write
		reg_wr(REG_ACK_LEN, 16'h0800);
		host_op(1'b1, 1'b0, 1'b0, {9'h000, PORT_ACK});
		for (int i = 0; i < 4; i++) begin
			check(host_rdata, words[i]);
			host_op(1'b0, 1'b0, 1'b1, 16'h0000);
		end
		@(posedge ref_clk);
		#1;
		check({15'h0000, fill_status[ST_ACK_FULL]}, 16'h0000);
		// descriptor headers: next offset, last, one txn, address
		for (int k = 0; k < 2; k++) begin
			@(posedge ref_clk);
			hdr_valid <= 1'b1;
			hdr_off   <= k ? 12'h018 : 12'h000;
			hdr.total_bytes <= k ? 10'd3 : 10'd14;
			hdr.last  <= k[0];
			hdr.format <= k[0];
			// limit bit set on both: iso descriptor must ignore it
			hdr.single_transaction_limit <= 1'b1;
			hdr.target_function_addr <= 7'h05 + 7'(k);
			@(posedge ref_clk);
			hdr_valid <= 1'b0;
			@(posedge ref_clk);
			#1;
			// 14 payload bytes end at 0x15, next header at 0x18
			v = k ? 16'h0024 : 16'h0018;
			check({4'h0, next_off}, v);
			check({15'h0000, list_end}, 16'(k));
			check({15'h0000, one_txn}, 16'(1 - k));
			check({9'h000, func_addr}, 16'h0005 + 16'(k));
		end
		// dma burst of four into the ack region, partner stalling
		slow <= 1'b1;
		reg_wr(REG_ACK_LEN, 16'h0800);
		reg_wr(REG_XFER_COUNT, 16'h0008);
		reg_wr(REG_DMA_CFG, 16'h0006);
		host_op(1'b1, 1'b0, 1'b0, {8'h00, 1'b1, PORT_ACK});
		@(posedge ref_clk);
		host.wdata <= 16'hBEEF;
		for (int n = 0; n < 200 && fill_status[ST_ACK_FULL] !== 1'b1; n++)
			@(posedge ref_clk);
		#1;
		check(16'(ack_count), 16'h0004);
		eng_rd(1'b0, 12'h006, b);
		check({8'h00, b}, 16'h00EF);
		eng_rd(1'b0, 12'h007, b);
		check({8'h00, b}, 16'h00BE);
		check({15'h0000, dma_req}, 16'h0000);
		// reset in mid-run: status, requests and ack length return
		@(posedge ref_clk);
		reset_n <= 1'b0;
		repeat (5) @(posedge ref_clk);
		reset_n <= 1'b1;
		#1;
		check({10'h000, fill_status}, 16'h0000);
		check({14'h0000, host_irq, dma_req}, 16'h0000);
		reg_rd(REG_ACK_LEN, v);
		check(v, RST_ACK_LEN);
		give_verdict();
	end
endmodule
